// ==== hdl/rpc_params.svh ====
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// Command codes, matched against each command byte
`define RPC_CMD_RGB_CTRL     8'hb0
`define RPC_CMD_INV_CTRL     8'hb4
`define RPC_CMD_PORCH_CTRL   8'hb5

// Field positions of the rgb_signal_control parameter
`define RPC_RGB_MODE_HI      6
`define RPC_RGB_MODE_LO      5
`define RPC_VSYNC_POL_BIT    3
`define RPC_HSYNC_POL_BIT    2
`define RPC_PCLK_EDGE_BIT    1
`define RPC_DE_POL_BIT       0

// Field position of the inversion_control parameter
`define RPC_INV_TYPE_BIT     2

// Field widths of blanking_porch_control
`define RPC_VPORCH_W         7
`define RPC_HPORCH_W         5

// Reset values
`define RPC_RGB_CTRL_RST     8'h40
`define RPC_INV_CTRL_RST     8'h00
`define RPC_VFRONT_RST       7'h08
`define RPC_VBACK_RST        7'h08
`define RPC_HBACK_RST        5'h02

// Porch limits
`define RPC_VPORCH_MIN       7'h02
`define RPC_HPORCH_MIN       5'h02
`define RPC_HPORCH_TOP       5'h1f
`define RPC_HPORCH_TOP_LEN   6'h20

`endif

// ==== hdl/rpc_pkg.sv ====
`default_nettype none

package rpc_pkg;

    typedef enum logic [2:0] {
        RPC_IDLE       = 3'b000,
        RPC_RGB_PAR    = 3'b001,
        RPC_INV_PAR    = 3'b010,
        RPC_VFRONT_PAR = 3'b011,
        RPC_VBACK_PAR  = 3'b100,
        RPC_ZERO_PAR   = 3'b101,
        RPC_HBACK_PAR  = 3'b110
    } rpc_state_t;

endpackage

`default_nettype wire

// ==== hdl/rpc_port_cfg.sv ====
// How it works
// - RGB control byte holds mode and four polarities
// - RGB control takes effect on parameter receipt
// - DE polarity bit: 0 high, 1 low
// - Clock edge bit: 0 rising, 1 falling
// - Sync polarity bit: 0 low, 1 high
// - Reset defaults: mode 10, polarities zero
// - Commands accepted only with extended enable high
// - Commands accepted in every operating state
// - Inversion byte bit 2: line or frame
// - Porch command: front, back, zero, horizontal bytes
// - Vertical porch code equals lines; 0,1 inhibited
// - Horizontal porch codes 0,1 inhibited; up to 32
`include "rpc_params.svh"

`default_nettype none

module rpc_port_cfg
#(
    parameter int PIX_W = 18
)
(
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               soft_reset_i,
    input  wire logic               extended_cmd_enable_i,
    input  wire logic               cmd_data_select_i,
    input  wire logic               write_strobe_n_i,
    input  wire logic [7:0]         cmd_data_i,
    input  wire logic               pixel_clock_i,
    input  wire logic               hsync_i,
    input  wire logic               vsync_i,
    input  wire logic               data_enable_i,
    input  wire logic [PIX_W-1:0]   pixel_data_i,
    output logic [1:0]              rgb_mode_select_o,
    output logic                    vertical_sync_polarity_sel_o,
    output logic                    horizontal_sync_polarity_sel_o,
    output logic                    pixel_clock_edge_sel_o,
    output logic                    data_enable_polarity_sel_o,
    output logic                    inversion_type_sel_o,
    output logic [6:0]              vertical_front_porch_o,
    output logic [6:0]              vertical_back_porch_o,
    output logic [4:0]              horizontal_back_porch_o,
    output logic [5:0]              hback_len_o,
    output logic                    hsync_active_o,
    output logic                    vsync_active_o,
    output logic                    de_active_o,
    output logic                    pixel_valid_o,
    output logic [PIX_W-1:0]        pixel_data_o
);

    localparam int SW = PIX_W + 15;

    // Flops reset to the pins' idle levels, so the strobe detector sees no edge at release
    localparam logic [SW-1:0] SYNC_IDLE = {{(SW - 11){1'b0}}, 11'h400};

    // Every pin except the two resets passes two flops; the pin bus and RGB port are both asynchronous
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] raw;

    assign raw = {pixel_clock_i, hsync_i, vsync_i, data_enable_i, pixel_data_i,
                  write_strobe_n_i, cmd_data_select_i, extended_cmd_enable_i, cmd_data_i};

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
        end
        else
        begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
        end
    end

    logic               pclk_s;
    logic               hs_s;
    logic               vs_s;
    logic               de_s;
    logic [PIX_W-1:0]   pix_s;
    logic               wr_n_s;
    logic               dsel_s;
    logic               ext_en_s;
    logic [7:0]         byte_s;

    assign {pclk_s, hs_s, vs_s, de_s, pix_s, wr_n_s, dsel_s, ext_en_s, byte_s} = sync2_r;

    // Write strobe rising edge marks one byte; strobe idles high
    logic wr_n_d_r;
    logic pclk_d_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_n_d_r <= 1'b1;
            pclk_d_r <= 1'b0;
        end
        else
        begin
            wr_n_d_r <= wr_n_s;
            pclk_d_r <= pclk_s;
        end
    end

    logic wr_stb;
    logic cmd_stb;
    logic par_stb;

    assign wr_stb  = wr_n_s & ~wr_n_d_r;
    assign cmd_stb = wr_stb & ~dsel_s;
    assign par_stb = wr_stb & dsel_s;

    // Command decoder; no power or sleep state gates it
    rpc_pkg::rpc_state_t state_r;
    rpc_pkg::rpc_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (cmd_stb)
        begin
            // Any other command, or one sent without the enable, drops the sequence
            state_nxt = rpc_pkg::RPC_IDLE;
            // The enable is judged on the command byte; its parameters follow freely
            if (ext_en_s)
            begin
                if (byte_s == `RPC_CMD_RGB_CTRL)
                    state_nxt = rpc_pkg::RPC_RGB_PAR;
                else if (byte_s == `RPC_CMD_INV_CTRL)
                    state_nxt = rpc_pkg::RPC_INV_PAR;
                else if (byte_s == `RPC_CMD_PORCH_CTRL)
                    state_nxt = rpc_pkg::RPC_VFRONT_PAR;
            end
        end
        else if (par_stb)
        begin
            unique case (state_r)
                rpc_pkg::RPC_IDLE:       state_nxt = rpc_pkg::RPC_IDLE;
                rpc_pkg::RPC_RGB_PAR:    state_nxt = rpc_pkg::RPC_IDLE;
                rpc_pkg::RPC_INV_PAR:    state_nxt = rpc_pkg::RPC_IDLE;
                rpc_pkg::RPC_VFRONT_PAR: state_nxt = rpc_pkg::RPC_VBACK_PAR;
                rpc_pkg::RPC_VBACK_PAR:  state_nxt = rpc_pkg::RPC_ZERO_PAR;
                rpc_pkg::RPC_ZERO_PAR:   state_nxt = rpc_pkg::RPC_HBACK_PAR;
                rpc_pkg::RPC_HBACK_PAR:  state_nxt = rpc_pkg::RPC_IDLE;
                default:                 state_nxt = rpc_pkg::RPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_r <= rpc_pkg::RPC_IDLE;
        else if (soft_reset_i)
            state_r <= rpc_pkg::RPC_IDLE;
        else
            state_r <= state_nxt;
    end

    // RGB signal control register
    // Loaded on the parameter edge itself; no frame boundary is awaited
    logic [7:0] rgb_ctrl_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rgb_ctrl_r <= `RPC_RGB_CTRL_RST;
        else if (soft_reset_i)
            rgb_ctrl_r <= `RPC_RGB_CTRL_RST;
        else if (par_stb && state_r == rpc_pkg::RPC_RGB_PAR)
            rgb_ctrl_r <= byte_s & 8'h6f;
    end

    assign rgb_mode_select_o              = rgb_ctrl_r[`RPC_RGB_MODE_HI:`RPC_RGB_MODE_LO];
    assign vertical_sync_polarity_sel_o   = rgb_ctrl_r[`RPC_VSYNC_POL_BIT];
    assign horizontal_sync_polarity_sel_o = rgb_ctrl_r[`RPC_HSYNC_POL_BIT];
    assign pixel_clock_edge_sel_o         = rgb_ctrl_r[`RPC_PCLK_EDGE_BIT];
    assign data_enable_polarity_sel_o     = rgb_ctrl_r[`RPC_DE_POL_BIT];

    // Inversion control register
    // Byte view of the reset value, so only the type bit is taken from it
    localparam logic [7:0] INV_CTRL_RST = `RPC_INV_CTRL_RST;
    logic inv_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            inv_r <= INV_CTRL_RST[`RPC_INV_TYPE_BIT];
        else if (soft_reset_i)
            inv_r <= INV_CTRL_RST[`RPC_INV_TYPE_BIT];
        else if (par_stb && state_r == rpc_pkg::RPC_INV_PAR)
            inv_r <= byte_s[`RPC_INV_TYPE_BIT];
    end

    assign inversion_type_sel_o = inv_r;

    // Porch registers; an inhibited code is refused and the old value kept
    logic [6:0] vfront_r;
    logic [6:0] vback_r;
    logic [4:0] hback_r;

    // Shared by both vertical fields; an inhibited code never reaches the timing generator
    function automatic logic vporch_legal(input logic [6:0] code);
        vporch_legal = code >= `RPC_VPORCH_MIN;
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            vfront_r <= `RPC_VFRONT_RST;
        else if (soft_reset_i)
            vfront_r <= `RPC_VFRONT_RST;
        else if (par_stb && state_r == rpc_pkg::RPC_VFRONT_PAR && vporch_legal(byte_s[6:0]))
            vfront_r <= byte_s[6:0];
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            vback_r <= `RPC_VBACK_RST;
        else if (soft_reset_i)
            vback_r <= `RPC_VBACK_RST;
        else if (par_stb && state_r == rpc_pkg::RPC_VBACK_PAR && vporch_legal(byte_s[6:0]))
            vback_r <= byte_s[6:0];
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hback_r <= `RPC_HBACK_RST;
        else if (soft_reset_i)
            hback_r <= `RPC_HBACK_RST;
        else if (par_stb && state_r == rpc_pkg::RPC_HBACK_PAR && byte_s[4:0] >= `RPC_HPORCH_MIN)
            hback_r <= byte_s[4:0];
    end

    assign vertical_front_porch_o  = vfront_r;
    assign vertical_back_porch_o   = vback_r;
    assign horizontal_back_porch_o = hback_r;
    // The top code saturates at 32; every lower legal code is its own length
    assign hback_len_o = (hback_r == `RPC_HPORCH_TOP) ? `RPC_HPORCH_TOP_LEN
                                                      : {1'b0, hback_r};

    // One polarity mux serves both sync inputs and data enable
    function automatic logic active_level(input logic pin, input logic high_active);
        active_level = high_active ? pin : ~pin;
    endfunction

    // RGB port front end, normalised to active high
    logic pclk_rise;
    logic pclk_fall;
    logic sample;
    logic de_act;

    assign pclk_rise = pclk_s & ~pclk_d_r;
    assign pclk_fall = ~pclk_s & pclk_d_r;
    assign sample    = pixel_clock_edge_sel_o ? pclk_fall : pclk_rise;
    assign de_act    = active_level(de_s, ~data_enable_polarity_sel_o);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hsync_active_o <= 1'b0;
            vsync_active_o <= 1'b0;
            de_active_o    <= 1'b0;
        end
        else
        begin
            hsync_active_o <= active_level(hs_s, horizontal_sync_polarity_sel_o);
            vsync_active_o <= active_level(vs_s, vertical_sync_polarity_sel_o);
            de_active_o    <= de_act;
        end
    end

    // Pixel data taken on every selected edge; valid flagged only with data enable active
    // Pixel data shares the clock's flop pair, so the two stay aligned
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pixel_valid_o <= 1'b0;
            pixel_data_o  <= '0;
        end
        else
        begin
            pixel_valid_o <= sample & de_act;
            if (sample)
                pixel_data_o <= pix_s;
        end
    end

endmodule

`default_nettype wire

// ==== tb/rpc_port_cfg_properties.sv ====
`default_nettype none
module rpc_port_cfg_properties (
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic       soft_reset_i,
    input wire logic       write_strobe_n_i,
    input wire logic       hsync_i,
    input wire logic       vsync_i,
    input wire logic       data_enable_i,
    input wire logic [1:0] rgb_mode_select_o,
    input wire logic       vertical_sync_polarity_sel_o,
    input wire logic       horizontal_sync_polarity_sel_o,
    input wire logic       pixel_clock_edge_sel_o,
    input wire logic       data_enable_polarity_sel_o,
    input wire logic       inversion_type_sel_o,
    input wire logic [6:0] vertical_front_porch_o,
    input wire logic [6:0] vertical_back_porch_o,
    input wire logic [4:0] horizontal_back_porch_o,
    input wire logic [5:0] hback_len_o,
    input wire logic       hsync_active_o,
    input wire logic       vsync_active_o,
    input wire logic       de_active_o,
    input wire logic       pixel_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [25:0] cfg;
    assign cfg = {rgb_mode_select_o, vertical_sync_polarity_sel_o,
                  horizontal_sync_polarity_sel_o, pixel_clock_edge_sel_o,
                  data_enable_polarity_sel_o, inversion_type_sel_o, vertical_front_porch_o,
                  vertical_back_porch_o, horizontal_back_porch_o};
    // Six edges cover two sync flops, the register and one edge of pin phase slack
    sequence s_bus_quiet;
        ($stable(write_strobe_n_i) && !soft_reset_i)[*6];
    endsequence
    sequence s_steady(pin, pol);
        (!soft_reset_i && $stable(pin) && $stable(pol))[*5];
    endsequence
    a_hback_len_map: assert property (hback_len_o == ((horizontal_back_porch_o == 5'h1f) ?
        6'h20 : {1'b0, horizontal_back_porch_o})) else $error("horizontal porch length wrong");
    a_soft_rgb_dflt: assert property (soft_reset_i |=> rgb_mode_select_o == 2'b10 &&
        cfg[23:19] == 5'h00) else $error("rgb defaults wrong");
    a_soft_porch_dflt: assert property (soft_reset_i |=> cfg[18:0] == {7'h08, 7'h08,
        5'h02}) else $error("porch defaults wrong");
    a_cfg_needs_write: assert property (s_bus_quiet |-> $stable(cfg))
        else $error("config moved without write");
    a_valid_one_cycle: assert property (pixel_valid_o |=> !pixel_valid_o)
        else $error("valid longer than one cycle");
    a_hs_polarity: assert property (s_steady(hsync_i, horizontal_sync_polarity_sel_o) |->
        hsync_active_o == (hsync_i ~^ horizontal_sync_polarity_sel_o)) else $error("hsync level");
    a_vs_polarity: assert property (s_steady(vsync_i, vertical_sync_polarity_sel_o) |->
        vsync_active_o == (vsync_i ~^ vertical_sync_polarity_sel_o)) else $error("vsync level");
    a_de_polarity: assert property (s_steady(data_enable_i, data_enable_polarity_sel_o) |->
        de_active_o == (data_enable_i ^ data_enable_polarity_sel_o)) else $error("de level");
endmodule
bind rpc_port_cfg rpc_port_cfg_properties u_chk (.*);
`default_nettype wire

// ==== tb/rpc_host_model.sv ====
`default_nettype none
module rpc_host_model (
    input  wire logic       core_clk_i,
    output var  logic       strobe_n_o,
    output var  logic       dc_o,
    output var  logic [7:0] data_o,
    output var  logic       pclk_o,
    output var  logic       de_o,
    output var  logic [17:0] pix_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        strobe_n_o = 1'b1;
        dc_o = 1'b1;
        data_o = 8'h00;
        pclk_o = 1'b0;
        de_o = 1'b0;
        pix_o = 18'h00000;
    end
    // Phases of four cycles keep above the three-cycle minimum of the synchroniser
    task automatic wr(input logic dc, input logic [7:0] b);
        @(negedge core_clk_i);
        dc_o = dc;
        data_o = b;
        strobe_n_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
        strobe_n_o = 1'b1;
        repeat (4) @(negedge core_clk_i);
        data_o = ~b;
    endtask
    // Pixel clock runs only inside a burst, 32 ns period; released lines are inverted
    task automatic px(input int n, input logic de);
        for (int i = 0; i < n; i++)
        begin
            @(negedge core_clk_i);
            de_o = de;
            pix_o = 18'h2a5a5 ^ 18'(i);
            repeat (3) @(negedge core_clk_i);
            pclk_o = 1'b1;
            repeat (4) @(negedge core_clk_i);
            pclk_o = 1'b0;
        end
        @(negedge core_clk_i);
        de_o = ~de;
        pix_o = ~pix_o;
        repeat (5) @(negedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// ==== tb/rpc_port_cfg_test.sv ====
`default_nettype none
module rpc_port_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i, rst_b_i, soft_reset_i, extended_cmd_enable_i;
    logic        cmd_data_select_i, write_strobe_n_i, pixel_clock_i, data_enable_i;
    logic        hsync_i, vsync_i;
    logic [7:0]  cmd_data_i;
    logic [17:0] pixel_data_i, pixel_data_o, last_pix;
    logic [1:0]  rgb_mode_select_o;
    logic        vertical_sync_polarity_sel_o, horizontal_sync_polarity_sel_o;
    logic        pixel_clock_edge_sel_o, data_enable_polarity_sel_o, inversion_type_sel_o;
    logic [6:0]  vertical_front_porch_o, vertical_back_porch_o;
    logic [4:0]  horizontal_back_porch_o;
    logic [5:0]  hback_len_o;
    logic        hsync_active_o, vsync_active_o, de_active_o, pixel_valid_o;
    int          error_cnt = 0, cmp_count = 0, vcnt = 0;
    wire logic [7:0]  rgb_w = {1'b0, rgb_mode_select_o, 1'b0, vertical_sync_polarity_sel_o,
        horizontal_sync_polarity_sel_o, pixel_clock_edge_sel_o, data_enable_polarity_sel_o};
    wire logic [18:0] porch_w = {vertical_front_porch_o, vertical_back_porch_o,
        horizontal_back_porch_o};
    rpc_port_cfg DUT (.*);
    rpc_host_model H (.core_clk_i(core_clk_i), .strobe_n_o(write_strobe_n_i),
        .dc_o(cmd_data_select_i), .data_o(cmd_data_i), .pclk_o(pixel_clock_i),
        .de_o(data_enable_i), .pix_o(pixel_data_i));
    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(negedge core_clk_i)
    begin
        if (pixel_valid_o === 1'b1)
        begin
            vcnt++;
            last_pix = pixel_data_o;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] p, input int n);
        H.wr(1'b0, c);
        for (int i = 0; i < n; i++)
            H.wr(1'b1, p[31-8*i -: 8]);
        repeat (3) @(negedge core_clk_i);
    endtask
    task automatic t_defaults;
        chk(32'(rgb_w), 32'h40);
        chk(32'(inversion_type_sel_o), 32'h0);
        chk(32'({porch_w, hback_len_o}), 32'({7'h08, 7'h08, 5'h02, 6'h02}));
        $display("defaults done");
    endtask
    task automatic soft_rst;
        soft_reset_i = 1'b1;
        @(negedge core_clk_i);
        soft_reset_i = 1'b0;
        @(negedge core_clk_i);
    endtask
    task automatic t_rgb;
        chk(32'({hsync_active_o, vsync_active_o, de_active_o}), 32'h4);
        cmd(8'hb0, 32'h2f000000, 1);
        chk(32'(rgb_w), 32'h2f);
        chk(32'({hsync_active_o, vsync_active_o, de_active_o}), 32'h3);
        cmd(8'hb0, 32'hff000000, 1);
        chk(32'(rgb_w), 32'h6f);
        soft_rst;
        chk(32'(rgb_w), 32'h40);
        chk(32'({hsync_active_o, vsync_active_o, de_active_o}), 32'h4);
        $display("rgb control done");
    endtask
    task automatic t_ext;
        extended_cmd_enable_i = 1'b0;
        cmd(8'hb4, 32'h04000000, 1);
        chk(32'(inversion_type_sel_o), 32'h0);
        extended_cmd_enable_i = 1'b1;
        cmd(8'hb4, 32'h04000000, 1);
        chk(32'(inversion_type_sel_o), 32'h1);
        cmd(8'hb4, 32'h00000000, 1);
        chk(32'(inversion_type_sel_o), 32'h0);
        $display("extended enable done");
    endtask
    task automatic t_porch;
        cmd(8'hb5, 32'h7f02001f, 4);
        chk(32'({porch_w, hback_len_o}), 32'({7'h7f, 7'h02, 5'h1f, 6'h20}));
        cmd(8'hb5, 32'h01000001, 4);
        chk(32'(porch_w), 32'({7'h7f, 7'h02, 5'h1f}));
        cmd(8'hb5, 32'h057f001d, 4);
        chk(32'({porch_w, hback_len_o}), 32'({7'h05, 7'h7f, 5'h1d, 6'h1d}));
        cmd(8'hb4, 32'h04000000, 1);
        soft_rst;
        chk(32'({porch_w, hback_len_o}), 32'({7'h08, 7'h08, 5'h02, 6'h02}));
        chk(32'(inversion_type_sel_o), 32'h0);
        $display("porch control done");
    endtask
    task automatic t_pixel;
        H.px(4, 1'b1);
        chk(32'(vcnt), 32'd4);
        chk(32'(last_pix), 32'(18'h2a5a6));
        H.px(3, 1'b0);
        chk(32'(vcnt), 32'd4);
        cmd(8'hb0, 32'h41000000, 1);
        H.px(2, 1'b0);
        chk(32'(vcnt), 32'd6);
        cmd(8'hb0, 32'h42000000, 1);
        H.px(2, 1'b1);
        chk(32'(vcnt), 32'd8);
        chk(32'(last_pix), 32'(18'h2a5a4));
        $display("pixel port done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize;
    end
    initial
    begin
        hsync_i = 1'b0;
        vsync_i = 1'b1;
        soft_reset_i = 1'b0;
        extended_cmd_enable_i = 1'b1;
        rst_b_i = 1'b0;
        repeat (5) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        t_defaults;
        t_rgb;
        t_ext;
        t_porch;
        t_pixel;
        summarize;
    end
endmodule
`default_nettype wire
